// ==== design/sdi_pkg.sv ====
// Package of constants for the switch-detect interrupt pin logic
package sdi_pkg;

  // ==========================================================
  // Clock and timing
  // ==========================================================
  localparam int CLK_PERIOD_NS      = 25;
  localparam int T_ACTIVE_NS        = 1000;
  localparam int T_IDLE_NS          = 500;
  localparam int ACTIVE_CYC         = (T_ACTIVE_NS / CLK_PERIOD_NS) > 0 ?
                                      (T_ACTIVE_NS / CLK_PERIOD_NS) : 1;
  localparam int IDLE_CYC           = (T_IDLE_NS + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;
  localparam int CNT_W              = 16;

  // ==========================================================
  // Event flags and reset values
  // ==========================================================
  localparam int       FLAG_W       = 8;
  localparam logic     SCHEME_RST   = 1'b0;
  localparam int       SYNC_STAGES  = 3;
  localparam int       CMD_W        = 8;
  // Read of event flag register: read bit 7 low, address in low bits
  localparam logic [7:0] CMD_RD_FLAGS = 8'h01;

  // Pin state machine
  typedef enum logic [1:0] {
    SDI_RELEASED,
    SDI_ASSERTED,
    SDI_PAUSE,
    SDI_IDLE_GAP
  } sdi_state_t;

endpackage : sdi_pkg

// ==== design/sdi_spi_front.sv ====
// SPI-clock front end: captures command byte and flag snapshot per frame
module sdi_spi_front
  import sdi_pkg::*;
(
  input  wire logic              sclk,
  input  wire logic              rst,
  input  wire logic              cs_n,
  input  wire logic [FLAG_W-1:0] flags,
  input  wire logic              mosi,
  output logic                   miso,
  output logic                   read_toggle,
  output logic                   frame_toggle
);

  // ==========================================================
  // Frame logic on the link clock
  // ==========================================================
  logic [FLAG_W-1:0] snap;
  logic [FLAG_W-1:0] next_snap;
  logic [CMD_W-1:0]  cmd;
  logic [CMD_W-1:0]  next_cmd;
  logic [3:0]        bit_cnt;
  logic [3:0]        next_bit_cnt;
  logic              next_read_toggle;
  logic              next_frame_toggle;
  logic              next_miso;

  // Snapshot on first edge, shift command, flag a full read command
  always_comb begin
    next_snap         = snap;
    next_cmd          = cmd;
    next_bit_cnt      = bit_cnt;
    next_read_toggle  = read_toggle;
    next_frame_toggle = frame_toggle;
    next_miso         = miso;
    if (bit_cnt == 4'h0) begin
      next_snap         = flags;
      next_frame_toggle = ~frame_toggle;
      next_miso         = flags[FLAG_W-1];
    end else if (bit_cnt < 4'(FLAG_W)) begin
      next_miso = snap[3'(FLAG_W - 1 - int'(bit_cnt))];
    end
    if (bit_cnt < 4'(CMD_W)) begin
      next_cmd     = {cmd[CMD_W-2:0], mosi};
      next_bit_cnt = bit_cnt + 4'h1;
      if (bit_cnt == 4'(CMD_W - 1) &&
          {cmd[CMD_W-2:0], mosi} == CMD_RD_FLAGS) begin
        next_read_toggle = ~read_toggle;
      end
    end
  end

  // Counter restarts each frame; cs_n is the frame's own reset
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt <= 4'h0;
      cmd     <= 8'h00;
    end else begin
      bit_cnt <= next_bit_cnt;
      cmd     <= next_cmd;
    end
  end

  // Toggles survive the frame so the system side sees each event once;
  // system reset gives them a known start, else the sync sees unknowns
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      snap         <= '0;
      read_toggle  <= 1'b0;
      frame_toggle <= 1'b0;
      miso         <= 1'b0;
    end else begin
      snap         <= next_snap;
      read_toggle  <= next_read_toggle;
      frame_toggle <= next_frame_toggle;
      miso         <= next_miso;
    end
  end

endmodule : sdi_spi_front

// ==== design/sdi_irq_pin.sv ====
// Interrupt pin logic: static and dynamic schemes, idle gap, SPI clear
module sdi_irq_pin
  import sdi_pkg::*;
#(
  parameter int ACTIVE_CYCLES = ACTIVE_CYC,
  parameter int IDLE_CYCLES   = IDLE_CYC
)
(
  input  wire logic              CLK,
  input  wire logic              SYS_RST,
  input  wire logic [FLAG_W-1:0] EVENT_SET,
  input  wire logic              RUN,
  input  wire logic              SCHEME_WR,
  input  wire logic              SCHEME_DATA,
  input  wire logic              SPI_SCLK,
  input  wire logic              SPI_CS_N,
  input  wire logic              SPI_MOSI,
  output logic                   SPI_MISO,
  output logic                   IRQ_N_OUT,
  output logic                   IRQ_N_OE,
  output logic [FLAG_W-1:0]      EVENT_FLAGS,
  output logic                   SCHEME
);

// Summary of operation
// - Interrupt pin is active-low open drain; driven low only on events.
// - Static scheme pulls the pin low on an event and holds it.
// - Static release only at chip-select rise of a flag-reading frame.
// - Flag register snapshot taken at first serial clock rise each frame.
// - A read command to the flag register clears the flags.
// - Dynamic scheme holds low for the active window, then releases.
// - Dynamic scheme keeps alternating low and released until flags read.
// - Dynamic read while low releases pin and clears at chip-select rise.
// - Dynamic read while released clears flags; no reassertion for them.
// - Reset selects the static scheme.
// - Scheme can change only while the run bit is low.
// - Idle gap starts after a flag read when events were pending.
// - Events in the gap set flags at once; pin waits for gap end.
// - Another read in the gap clears flags; no assertion at gap end.
// - Event detection continues without any SPI activity.

  // ==========================================================
  // Link-side front end
  // ==========================================================
  logic rd_tgl;
  logic fr_tgl;
  logic miso_link;

  sdi_spi_front u_front (
    .sclk         (SPI_SCLK),
    .rst          (SYS_RST),
    .cs_n         (SPI_CS_N),
    .flags        (EVENT_FLAGS),
    .mosi         (SPI_MOSI),
    .miso         (miso_link),
    .read_toggle  (rd_tgl),
    .frame_toggle (fr_tgl)
  );

  // ==========================================================
  // Synchronisers: chip select level and read toggle
  // ==========================================================
  logic [SYNC_STAGES-1:0] cs_sync;
  logic [SYNC_STAGES-1:0] rd_sync;
  logic [SYNC_STAGES-1:0] next_cs_sync;
  logic [SYNC_STAGES-1:0] next_rd_sync;
  logic                   cs_level;
  logic                   rd_level;
  logic                   next_cs_level;
  logic                   next_rd_level;

  // Change accepted once stages two and three agree
  always_comb begin
    next_cs_sync  = {cs_sync[SYNC_STAGES-2:0], SPI_CS_N};
    next_rd_sync  = {rd_sync[SYNC_STAGES-2:0], rd_tgl};
    next_cs_level = (cs_sync[1] == cs_sync[2]) ? cs_sync[2] : cs_level;
    next_rd_level = (rd_sync[1] == rd_sync[2]) ? rd_sync[2] : rd_level;
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      cs_sync  <= 3'h7;
      rd_sync  <= 3'h0;
      cs_level <= 1'b1;
      rd_level <= 1'b0;
    end else begin
      cs_sync  <= next_cs_sync;
      rd_sync  <= next_rd_sync;
      cs_level <= next_cs_level;
      rd_level <= next_rd_level;
    end
  end

  // ==========================================================
  // Read bookkeeping
  // ==========================================================
  logic read_seen;
  logic next_read_seen;
  logic cs_rise;
  logic rd_pulse;
  logic frame_read;

  // Read toggle is reliable at chip-select rise: it changed mid-frame
  assign rd_pulse   = (next_rd_level != rd_level);
  assign cs_rise    = next_cs_level & ~cs_level;
  assign frame_read = cs_rise & (read_seen | rd_pulse);

  always_comb begin
    next_read_seen = read_seen;
    if (cs_rise) begin
      next_read_seen = 1'b0;
    end else if (rd_pulse) begin
      next_read_seen = 1'b1;
    end
  end

  // ==========================================================
  // Scheme select and event flags
  // ==========================================================
  logic [FLAG_W-1:0] next_flags;
  logic              next_scheme;
  sdi_state_t        state;
  sdi_state_t        next_state;
  logic [CNT_W-1:0]  cnt;
  logic [CNT_W-1:0]  next_cnt;
  logic              gap_read;
  logic              next_gap_read;
  logic              in_gap;

  assign in_gap = (state == SDI_IDLE_GAP);

  // Set beats clear so an event landing on the clear is kept
  always_comb begin
    next_scheme = SCHEME;
    if (SCHEME_WR && !RUN) begin
      next_scheme = SCHEME_DATA;
    end
    next_flags = EVENT_FLAGS;
    if (frame_read || (in_gap && rd_pulse)) begin
      next_flags = '0;
    end
    next_flags = next_flags | EVENT_SET;
  end

  // ==========================================================
  // Pin state machine
  // ==========================================================
  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_gap_read = gap_read;
    unique case (state)
      SDI_RELEASED: begin
        if (|EVENT_FLAGS) begin
          next_state = SDI_ASSERTED;
          next_cnt   = '0;
        end
      end
      SDI_ASSERTED: begin
        next_cnt = cnt + 16'h0001;
        if (frame_read) begin
          next_state    = SDI_IDLE_GAP;
          next_cnt      = '0;
          next_gap_read = 1'b0;
        end else if (SCHEME &&
                     cnt >= CNT_W'(ACTIVE_CYCLES - 1)) begin
          next_state = SDI_PAUSE;
          next_cnt   = '0;
        end
      end
      SDI_PAUSE: begin
        next_cnt = cnt + 16'h0001;
        if (frame_read) begin
          next_state    = SDI_IDLE_GAP;
          next_cnt      = '0;
          next_gap_read = 1'b0;
        end else if (cnt >= CNT_W'(ACTIVE_CYCLES - 1)) begin
          next_state = SDI_ASSERTED;
          next_cnt   = '0;
        end
      end
      SDI_IDLE_GAP: begin
        next_cnt = cnt + 16'h0001;
        if (rd_pulse) begin
          next_gap_read = 1'b1;
        end
        if (cnt >= CNT_W'(IDLE_CYCLES - 1)) begin
          next_state = SDI_RELEASED;
          next_cnt   = '0;
        end
      end
    endcase
  end

  // Gap-end reassert suppressed when a later read cleared the flags
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state       <= SDI_RELEASED;
      cnt         <= '0;
      gap_read    <= 1'b0;
      read_seen   <= 1'b0;
      EVENT_FLAGS <= '0;
      SCHEME      <= SCHEME_RST;
      IRQ_N_OE    <= 1'b0;
      IRQ_N_OUT   <= 1'b0;
    end else begin
      state       <= next_state;
      cnt         <= next_cnt;
      gap_read    <= next_gap_read;
      read_seen   <= next_read_seen;
      EVENT_FLAGS <= next_flags;
      SCHEME      <= next_scheme;
      IRQ_N_OE    <= (next_state == SDI_ASSERTED);
      IRQ_N_OUT   <= 1'b0;
    end
  end

  // Serial data passes straight from the link domain
  assign SPI_MISO = miso_link;

endmodule : sdi_irq_pin

// ==== bench/sdi_irq_pin_chk.sv ====
// Assertion checker for the interrupt pin logic ports
module sdi_irq_pin_chk
  import sdi_pkg::*;
#(
  parameter int ACTIVE_CYCLES = ACTIVE_CYC,
  parameter int IDLE_CYCLES   = IDLE_CYC
)
(
  input wire logic              CLK,
  input wire logic              SYS_RST,
  input wire logic [FLAG_W-1:0] EVENT_SET,
  input wire logic              RUN,
  input wire logic              SCHEME_WR,
  input wire logic              SCHEME_DATA,
  input wire logic              SPI_SCLK,
  input wire logic              SPI_CS_N,
  input wire logic              SPI_MOSI,
  input wire logic              SPI_MISO,
  input wire logic              IRQ_N_OUT,
  input wire logic              IRQ_N_OE,
  input wire logic [FLAG_W-1:0] EVENT_FLAGS,
  input wire logic              SCHEME
);
  logic [7:0] cs_age;
  logic [7:0] next_cs_age;
  logic [7:0] oe_run;
  logic [7:0] next_oe_run;
  // ==========================================================
  // Helper counters
  // ==========================================================
  // Saturating, so a long idle still reads as long
  always_comb begin
    next_cs_age = SPI_CS_N ? cs_age + {7'h00, ~&cs_age} : 8'h00;
    next_oe_run = IRQ_N_OE ? oe_run + {7'h00, ~&oe_run} : 8'h00;
    if (SYS_RST) begin
      next_cs_age = 8'hFF;
      next_oe_run = 8'h00;
    end
  end
  always_ff @(posedge CLK) begin
    cs_age <= next_cs_age;
    oe_run <= next_oe_run;
  end
  // ==========================================================
  // Properties
  // ==========================================================
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_cs_low;
    !SPI_CS_N [*6];
  endsequence
  sequence s_cleared;
    EVENT_FLAGS != 8'h00 ##1 EVENT_FLAGS == 8'h00;
  endsequence
  a_od_data: assert property (IRQ_N_OUT == 1'b0)
    else $error("pin data not low");
  a_flag_set: assert property (
    EVENT_SET != 8'h00 |=>
    (EVENT_FLAGS & $past(EVENT_SET)) == $past(EVENT_SET))
    else $error("event flag not set");
  a_scheme_lock: assert property (
    SCHEME_WR && RUN |=> $stable(SCHEME))
    else $error("scheme changed while running");
  a_scheme_wr: assert property (
    SCHEME_WR && !RUN |=> SCHEME == $past(SCHEME_DATA))
    else $error("scheme write lost");
  a_static_hold: assert property (
    s_cs_low ##0 (IRQ_N_OE && !SCHEME) |=> IRQ_N_OE)
    else $error("pin released inside frame");
  a_static_rel: assert property (
    $fell(IRQ_N_OE) && !SCHEME |-> cs_age inside {[1:12]})
    else $error("pin released without frame end");
  a_clear_read: assert property (
    s_cleared |-> cs_age inside {[1:12]} ||
    (!SPI_CS_N && !IRQ_N_OE))
    else $error("flags cleared without frame end");
  a_static_set: assert property (
    !SCHEME && EVENT_FLAGS != 8'h00 && cs_age > IDLE_CYCLES + 8
    |-> ##[0:3] IRQ_N_OE)
    else $error("pending event not driven");
  a_dyn_window: assert property (
    SCHEME |-> oe_run <= ACTIVE_CYCLES)
    else $error("active window too long");
endmodule : sdi_irq_pin_chk

bind sdi_irq_pin sdi_irq_pin_chk #(
  .ACTIVE_CYCLES(ACTIVE_CYCLES), .IDLE_CYCLES(IDLE_CYCLES)) u_chk (
  .CLK(CLK), .SYS_RST(SYS_RST), .EVENT_SET(EVENT_SET), .RUN(RUN),
  .SCHEME_WR(SCHEME_WR), .SCHEME_DATA(SCHEME_DATA),
  .SPI_SCLK(SPI_SCLK), .SPI_CS_N(SPI_CS_N), .SPI_MOSI(SPI_MOSI),
  .SPI_MISO(SPI_MISO), .IRQ_N_OUT(IRQ_N_OUT), .IRQ_N_OE(IRQ_N_OE),
  .EVENT_FLAGS(EVENT_FLAGS), .SCHEME(SCHEME));

// ==== bench/sdi_host_model.sv ====
// Behavioural SPI host issuing one command frame per request
module sdi_host_model (
  input  wire logic       go,
  input  wire logic [7:0] cmd,
  input  wire logic       miso,
  output logic [7:0]      rdata,
  output logic            sclk,
  output logic            cs_n,
  output logic            mosi,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // Frame engine
  // ==========================================================
  // Mode 0, MSB first; clock rests low between frames
  // the modelled host keeps its own supply on throughout
  initial begin
    rdata = 8'h00;
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    busy = 1'b0;
    #7;
    forever begin
      wait (go);
      busy = 1'b1;
      cs_n = 1'b0;
      for (int i = 7; i >= 0; i--) begin
        mosi = cmd[i];
        #32 sclk = 1'b1;
        #32 rdata = {rdata[6:0], miso}; // Bit stands since the rise
        sclk = 1'b0;
      end
      #32 cs_n = 1'b1;
      mosi = ~mosi; // No stale bit once deselected
      #200 busy = 1'b0; // Keeps frames well apart
      wait (!go);
    end
  end
endmodule : sdi_host_model

// ==== bench/sdi_irq_pin_tb.sv ====
// Self-checking testbench of the interrupt pin logic
module sdi_irq_pin_tb import sdi_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int ACT = 40;
  localparam int IDL = 40;
  logic [7:0] ev, cmd, flags, rd;
  logic miso;
  logic clk, rst, run, swr, sdat, go, busy, sclk, cs_n, mosi, oe, sch;
  int fails, n_checks;
  // ==========================================================
  // Clock, design and host
  // ==========================================================
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  sdi_irq_pin #(.ACTIVE_CYCLES(ACT), .IDLE_CYCLES(IDL)) u_sdi_irq_pin (
    .CLK(clk), .SYS_RST(rst), .EVENT_SET(ev), .RUN(run),
    .SCHEME_WR(swr), .SCHEME_DATA(sdat), .SPI_SCLK(sclk),
    .SPI_CS_N(cs_n), .SPI_MOSI(mosi), .SPI_MISO(miso), .IRQ_N_OUT(),
    .IRQ_N_OE(oe), .EVENT_FLAGS(flags), .SCHEME(sch));
  sdi_host_model u_sdi_host_model (.go(go), .cmd(cmd), .miso(miso),
    .rdata(rd), .sclk(sclk),
    .cs_n(cs_n), .mosi(mosi), .busy(busy));
  // ==========================================================
  // Helpers
  // ==========================================================
  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic pulse(input logic [7:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 8'h00;
  endtask : pulse
  task automatic frame(input logic [7:0] c);
    @(posedge clk);
    cmd <= c;
    go <= 1'b1;
    wait (busy);
    @(posedge clk);
    go <= 1'b0;
    wait (!busy);
    tick(1);
  endtask : frame
  // Bounded wait, so a dead pin cannot hang the run
  task automatic wait_oe(input logic v);
    int k;
    k = 0;
    while (oe !== v && k < 200) begin
      tick(1);
      k++;
    end
    chk("pin", {7'h00, v}, {7'h00, oe});
  endtask : wait_oe
  task automatic hold(input logic v, input int n);
    logic bad;
    bad = 1'b0;
    repeat (n) begin
      tick(1);
      if (oe !== v) bad = 1'b1;
    end
    chk("pin held", 8'h00, {7'h00, bad});
  endtask : hold
  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_static();
    pulse(8'h05);
    tick(3);
    chk("flags", 8'h05, flags);
    chk("pin", 8'h01, {7'h00, oe});
    hold(1'b1, 40);
    frame(8'h02);
    hold(1'b1, 8);
    chk("flags", 8'h05, flags);
    frame(8'h01);
    chk("miso", 8'h05, rd);
    chk("flags", 8'h00, flags);
    chk("pin", 8'h00, {7'h00, oe});
  endtask : t_static
  task automatic t_gap();
    tick(IDL + 8); // Let the gap of the last read run out first
    pulse(8'h10);
    frame(8'h01);
    pulse(8'h40);
    tick(1);
    chk("flags", 8'h40, flags);
    hold(1'b0, 20);
    wait_oe(1'b1);
    frame(8'h01);
    pulse(8'h08);
    frame(8'h01);
    chk("flags", 8'h00, flags);
    hold(1'b0, 80);
  endtask : t_gap
  task automatic t_scheme();
    @(posedge clk);
    swr <= 1'b1;
    sdat <= 1'b1;
    @(posedge clk);
    swr <= 1'b0;
    run <= 1'b0;
    tick(2);
    chk("scheme", 8'h00, {7'h00, sch});
    @(posedge clk);
    swr <= 1'b1;
    @(posedge clk);
    swr <= 1'b0;
    tick(2);
    chk("scheme", 8'h01, {7'h00, sch});
  endtask : t_scheme
  task automatic t_dyn();
    int k;
    k = 0;
    pulse(8'h21);
    wait_oe(1'b1);
    while (oe === 1'b1 && k < 200) begin
      tick(1);
      k++;
    end
    chk("active", ACT[7:0], k[7:0]);
    wait_oe(1'b1);
    frame(8'h01);
    chk("pin", 8'h00, {7'h00, oe});
    chk("flags", 8'h00, flags);
    pulse(8'h03);
    wait_oe(1'b1);
    wait_oe(1'b0);
    frame(8'h01);
    chk("flags", 8'h00, flags);
    hold(1'b0, 150);
  endtask : t_dyn
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude
  // ==========================================================
  // Main sequence and watchdog
  // ==========================================================
  initial begin
    rst = 1'b1;
    run = 1'b1;
    ev = 8'h00;
    swr = 1'b0;
    sdat = 1'b0;
    go = 1'b0;
    cmd = 8'h00;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    chk("scheme", 8'h00, {7'h00, sch});
    chk("pin", 8'h00, {7'h00, oe});
    t_static();
    t_gap();
    t_scheme();
    t_dyn();
    conclude();
  end
  // Whole run needs about 20 us; this leaves ample margin
  initial begin
    #300us;
    fails++;
    conclude();
  end
endmodule : sdi_irq_pin_tb
